// ==== design/uart_rx_error_irq_wake.v ====
// UART receiver with error flags, interrupt request, address detect and RX wake-up
`timescale 1ns/100ps
`default_nettype none
`include "rx_err_regs.vh"

module uart_rx_error_irq_wake #(
    parameter STARTUP_COUNT = `STARTUP_CYCLES
) (
    // Clock, reset and enable
    input  wire        CLK_IN,
    input  wire        RST_N_IN,
    input  wire        CE_IN,
    // APB slave
    input  wire        PSEL_IN,
    input  wire        PENABLE_IN,
    input  wire        PWRITE_IN,
    input  wire [11:0] PADDR_IN,
    input  wire [31:0] PWDATA_IN,
    output reg  [31:0] PRDATA_OUT,
    output reg         PREADY_OUT,
    output reg         PSLVERR_OUT,
    // Serial line and transmitter status
    input  wire        RX_IN,
    input  wire        TX_EMPTY_IN,
    input  wire        TX_IDLE_IN,
    // Interrupt request, low pulse, and wake event
    output reg         IRQ_N_OUT,
    output reg         WAKE_OUT
);
    // ============================================================
    // Receiver states
    localparam S_IDLE  = 2'h0;
    localparam S_START = 2'h1;
    localparam S_DATA  = 2'h2;
    localparam S_STOP  = 2'h3;

    reg  [7:0]  uart_control_one_q;
    reg  [7:0]  uart_control_two_q;
    reg  [7:0]  baud_divisor_reg_q;
    reg  [7:0]  power_q;
    reg         overrun_flag_q;
    reg         status_seen_q;
    reg  [1:0]  state_q;
    reg  [3:0]  phase_q;
    reg  [3:0]  bitn_q;
    reg  [8:0]  shift_q;
    reg         par_q;
    reg         noise_acc_q;
    reg         ferr_q;
    reg         perr_q;
    reg         stop2_q;
    reg  [7:0]  div_q;
    reg         rx_prev_q;
    reg         waking_q;
    reg  [15:0] startup_q;
    reg         wake_pend_q;
    reg         tx_empty_prev_q;
    reg         tx_idle_prev_q;

    wire        clk_off   = power_q[`PW_CLK_OFF];
    wire        run       = CE_IN && !clk_off && !waking_q;
    wire        nine      = uart_control_one_q[`C1_NINE_BIT];
    wire        par_en    = uart_control_one_q[`C1_PARITY_EN];
    wire        rx_on     = uart_control_two_q[`C2_RX_EN] && power_q[`PW_UART_EN] &&
                            uart_control_one_q[`C1_MODE];
    wire        rx_int_en = uart_control_two_q[`C2_RX_INT];
    wire        tick      = run && (div_q == 8'h00);
    wire [3:0]  nbits     = nine ? 4'h9 : 4'h8;
    wire        vote;
    wire        noisy;
    wire        fifo_empty;
    wire        fifo_full;
    wire [11:0] fifo_rd;
    wire        done;
    wire        overrun;
    wire        apb_acc   = PSEL_IN && PENABLE_IN && !PREADY_OUT;
    wire        rd_stat   = apb_acc && !PWRITE_IN && (PADDR_IN == `OFS_STATUS);
    wire        rd_data   = apb_acc && !PWRITE_IN && (PADDR_IN == `OFS_DATA);
    wire        pop       = rd_data && status_seen_q;
    wire [11:0] push_word;
    wire        top_bit;
    wire        fall;

    // ============================================================
    // Bit sampling at sixteen times the baud rate
    rx_sampler u_sampler (
        .clk     (CLK_IN),
        .rst_n   (RST_N_IN),
        .en      (CE_IN),
        .tick    (tick),
        .rx      (RX_IN),
        .phase   (phase_q),
        .bit_q   (vote),
        .noisy_q (noisy)
    );

    // ============================================================
    // Receive buffer: {noise, parity, framing, nine data bits}
    assign done      = tick && (state_q == S_STOP) && (phase_q == 4'ha) && !stop2_q;
    assign overrun   = done && fifo_full && !pop;
    // Noise of the last stop bit is decided in the same cycle as the push
    assign push_word = {noise_acc_q | noisy, perr_q, ferr_q | !vote, shift_q};
    assign top_bit   = nine ? shift_q[8] : shift_q[7];

    rx_fifo2 #(
        .WIDTH (12),
        .DEPTH (2)
    ) u_fifo (
        .clk   (CLK_IN),
        .rst_n (RST_N_IN),
        .en    (CE_IN),
        .push  (done && !overrun),
        .wdata (push_word),
        .pop   (pop),
        .rdata (fifo_rd),
        .empty (fifo_empty),
        .full  (fifo_full)
    );

    // ============================================================
    // Baud divider; frozen with the UART clock, so frames pause
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN)
            div_q <= 8'h00;
        else if (run)
            div_q <= (div_q == 8'h00) ? baud_divisor_reg_q : div_q - 8'h01;
    end

    // ============================================================
    // Receive state machine
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_q     <= S_IDLE;
            phase_q     <= 4'h0;
            bitn_q      <= 4'h0;
            shift_q     <= 9'h000;
            par_q       <= 1'b0;
            noise_acc_q <= 1'b0;
            ferr_q      <= 1'b0;
            perr_q      <= 1'b0;
            stop2_q     <= 1'b0;
        end else if (tick) begin
            phase_q <= phase_q + 4'h1;
            case (state_q)
                S_IDLE: begin
                    phase_q <= 4'h0;
                    if (rx_on && !RX_IN) begin
                        state_q     <= S_START;
                        noise_acc_q <= 1'b0;
                        ferr_q      <= 1'b0;
                        par_q       <= uart_control_one_q[`C1_PARITY_ODD];
                        bitn_q      <= 4'h0;
                    end
                end
                S_START: begin
                    if (phase_q == 4'ha) begin
                        noise_acc_q <= noisy;
                        state_q     <= vote ? S_IDLE : S_DATA;
                    end
                end
                S_DATA: begin
                    if (phase_q == 4'ha) begin
                        noise_acc_q <= noise_acc_q | noisy;
                        if (bitn_q < nbits) begin
                            shift_q <= nine ? {vote, shift_q[8:1]} : {1'b0, vote, shift_q[7:1]};
                            par_q   <= par_q ^ vote;
                        end
                        bitn_q <= bitn_q + 4'h1;
                        if (bitn_q == (par_en ? nbits : nbits - 4'h1)) begin
                            // Parity bit is the last one sampled when enabled; it is not shifted in
                            perr_q  <= par_en && ((par_q ^ vote) != 1'b0);
                            state_q <= S_STOP;
                            stop2_q <= uart_control_one_q[`C1_TWO_STOP];
                        end
                    end
                end
                S_STOP: begin
                    if (phase_q == 4'ha) begin
                        ferr_q <= ferr_q | !vote;
                        // First of two stops may carry noise as well
                        noise_acc_q <= noise_acc_q | noisy;
                        if (stop2_q)
                            stop2_q <= 1'b0;
                        else
                            state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ============================================================
    // Overrun flag; set wins over the read-sequence clear
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            overrun_flag_q <= 1'b0;
            status_seen_q  <= 1'b0;
        end else if (CE_IN) begin
            if (overrun)
                overrun_flag_q <= 1'b1;
            else if (pop)
                overrun_flag_q <= 1'b0;
            if (rd_stat)
                status_seen_q <= 1'b1;
            else if (rd_data)
                status_seen_q <= 1'b0;
        end
    end

    // ============================================================
    // Wake-up: edge on RX while clock stopped, then start-up delay
    assign fall = rx_prev_q && !RX_IN;

    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rx_prev_q   <= 1'b1;
            waking_q    <= 1'b0;
            startup_q   <= 16'h0000;
            wake_pend_q <= 1'b0;
            WAKE_OUT    <= 1'b0;
        end else if (CE_IN) begin
            rx_prev_q <= RX_IN;
            WAKE_OUT  <= 1'b0;
            if (clk_off && fall && uart_control_two_q[`C2_WAKE] && rx_on && rx_int_en) begin
                WAKE_OUT    <= 1'b1;
                waking_q    <= 1'b1;
                startup_q   <= STARTUP_COUNT[15:0];
                wake_pend_q <= power_q[`PW_GLOBAL_INT] && power_q[`PW_SERIAL_INT];
            end else if (waking_q && !clk_off) begin
                // Receiver is held off until the oscillator settles
                if (startup_q <= 16'h0001)
                    waking_q <= 1'b0;
                else
                    startup_q <= startup_q - 16'h0001;
            end else if (!waking_q) begin
                wake_pend_q <= 1'b0;
            end
        end
    end

    // ============================================================
    // Interrupt request: one-cycle low pulse on any enabled event
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            IRQ_N_OUT       <= 1'b1;
            tx_empty_prev_q <= 1'b0;
            tx_idle_prev_q  <= 1'b0;
        end else if (CE_IN) begin
            tx_empty_prev_q <= TX_EMPTY_IN;
            tx_idle_prev_q  <= TX_IDLE_IN;
            IRQ_N_OUT <= !(
                (TX_EMPTY_IN && !tx_empty_prev_q && uart_control_two_q[`C2_TX_EMPTY_INT]) ||
                (TX_IDLE_IN && !tx_idle_prev_q && uart_control_two_q[`C2_TX_IDLE_INT]) ||
                (rx_int_en && done && !overrun &&
                 (!uart_control_two_q[`C2_ADDR_DET] || top_bit)) ||
                (rx_int_en && overrun) ||
                (wake_pend_q && waking_q && !clk_off && startup_q <= 16'h0001));
        end
    end

    // ============================================================
    // APB slave: one wait state, error on unmapped address
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            uart_control_one_q <= `RST_CTRL_ONE;
            uart_control_two_q <= `RST_CTRL_TWO;
            baud_divisor_reg_q <= `RST_BAUD;
            power_q            <= `RST_POWER;
            PRDATA_OUT         <= 32'h0000_0000;
            PREADY_OUT         <= 1'b0;
            PSLVERR_OUT        <= 1'b0;
        end else if (CE_IN) begin
            PREADY_OUT  <= PSEL_IN && PENABLE_IN && !PREADY_OUT;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT  <= 32'h0000_0000;
            // Status is read-only; writes to it are ignored
            if (apb_acc && PWRITE_IN) begin
                case (PADDR_IN)
                    `OFS_CTRL_ONE: uart_control_one_q <= {PWDATA_IN[7:1], uart_control_one_q[0]};
                    `OFS_CTRL_TWO: uart_control_two_q <= PWDATA_IN[7:0];
                    `OFS_BAUD:     baud_divisor_reg_q <= PWDATA_IN[7:0];
                    `OFS_POWER:    power_q            <= PWDATA_IN[7:0];
                    `OFS_STATUS, `OFS_DATA: ;
                    default:       PSLVERR_OUT <= 1'b1;
                endcase
            end else if (apb_acc) begin
                case (PADDR_IN)
                    `OFS_STATUS: PRDATA_OUT <= {24'h000000, TX_EMPTY_IN, TX_IDLE_IN,
                                                !fifo_empty,
                                                state_q == S_IDLE, overrun_flag_q,
                                                !fifo_empty && fifo_rd[11],
                                                !fifo_empty && fifo_rd[9],
                                                !fifo_empty && fifo_rd[10]};
                    `OFS_DATA:   PRDATA_OUT <= {24'h000000, fifo_rd[7:0]};
                    `OFS_CTRL_ONE: PRDATA_OUT <= {24'h000000, uart_control_one_q[7:1], fifo_rd[8]};
                    `OFS_CTRL_TWO: PRDATA_OUT <= {24'h000000, uart_control_two_q};
                    `OFS_BAUD:     PRDATA_OUT <= {24'h000000, baud_divisor_reg_q};
                    `OFS_POWER:    PRDATA_OUT <= {24'h000000, power_q};
                    default:       PSLVERR_OUT <= 1'b1;
                endcase
            end
        end
    end
endmodule

`default_nettype wire

// ==== shared/rx_err_regs.vh ====
// Register offsets, field positions, reset values and timing counts of the receive/error block
`ifndef RX_ERR_REGS_VH
`define RX_ERR_REGS_VH

// ============================================================
// Register byte addresses (APB, one aligned word each)
`define OFS_STATUS      12'h000
`define OFS_DATA        12'h004
`define OFS_CTRL_ONE    12'h008
`define OFS_CTRL_TWO    12'h00c
`define OFS_BAUD        12'h010
`define OFS_POWER       12'h014

// ============================================================
// Status field positions
`define ST_PARITY       0
`define ST_FRAMING      1
`define ST_NOISE        2
`define ST_OVERRUN      3
`define ST_RX_IDLE      4
`define ST_RX_AVAIL     5
`define ST_TX_IDLE      6
`define ST_TX_EMPTY     7

// ============================================================
// Control one field positions
`define C1_MODE         7
`define C1_NINE_BIT     6
`define C1_PARITY_EN    5
`define C1_PARITY_ODD   4
`define C1_TWO_STOP     3
`define C1_BIT8         0

// ============================================================
// Control two field positions
`define C2_RX_EN        7
`define C2_ADDR_DET     4
`define C2_WAKE         3
`define C2_RX_INT       2
`define C2_TX_IDLE_INT  1
`define C2_TX_EMPTY_INT 0

// ============================================================
// Power control field positions
`define PW_CLK_OFF      0
`define PW_GLOBAL_INT   1
`define PW_SERIAL_INT   2
`define PW_UART_EN      3

// ============================================================
// Reset values
`define RST_CTRL_ONE    8'h00
`define RST_CTRL_TWO    8'h00
`define RST_BAUD        8'h00
`define RST_POWER       8'h00

// ============================================================
// Timing: oscillator start-up after wake, in ns, and its cycle count at 50 MHz
`define STARTUP_NS      2000
`define CLK_PERIOD_NS   20
`define STARTUP_CYCLES  ((`STARTUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== design/rx_sampler.v ====
// Majority vote over three of sixteen samples per bit, with noise detection
`timescale 1ns/100ps
`default_nettype none

module rx_sampler (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    input  wire       en,
    // Sample strobe and line
    input  wire       tick,
    input  wire       rx,
    input  wire [3:0] phase,
    // Decision
    output reg        bit_q,
    output reg        noisy_q
);
    reg [2:0] smp_q;

    // ============================================================
    // Collect samples 7, 8 and 9, then vote on sample 9
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            smp_q   <= 3'h0;
            bit_q   <= 1'b1;
            noisy_q <= 1'b0;
        end else if (en && tick) begin
            if (phase == 4'h7)
                smp_q[0] <= rx;
            if (phase == 4'h8)
                smp_q[1] <= rx;
            if (phase == 4'h9) begin
                // Disagreement among samples marks noise
                bit_q   <= (smp_q[0] & smp_q[1]) | (smp_q[0] & rx) | (smp_q[1] & rx);
                noisy_q <= !((smp_q[0] == smp_q[1]) && (smp_q[1] == rx));
            end
        end
    end
endmodule

`default_nettype wire

// ==== design/rx_fifo2.v ====
// Two-entry receive FIFO, each entry a data word with its error flags
`timescale 1ns/100ps
`default_nettype none

module rx_fifo2 #(
    parameter WIDTH = 12,
    parameter DEPTH = 2
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_n,
    input  wire             en,
    // Write side
    input  wire             push,
    input  wire [WIDTH-1:0] wdata,
    // Read side
    input  wire             pop,
    output wire [WIDTH-1:0] rdata,
    output wire             empty,
    output wire             full
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [1:0]       cnt_q;
    reg             rd_q;
    reg             wr_q;
    integer         i;
    // A push while full is taken when a pop frees a slot in the same cycle
    wire            do_pop  = pop && !empty;
    wire            do_push = push && (!full || do_pop);

    assign empty = (cnt_q == 2'h0);
    assign full  = (cnt_q == DEPTH[1:0]);
    assign rdata = mem_q[rd_q];

    // ============================================================
    // Pointers and storage; push on full is dropped by the caller
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 2'h0;
            rd_q  <= 1'b0;
            wr_q  <= 1'b0;
            for (i = 0; i < DEPTH; i = i + 1)
                mem_q[i] <= {WIDTH{1'b0}};
        end else if (en) begin
            if (do_push) begin
                mem_q[wr_q] <= wdata;
                wr_q        <= ~wr_q;
            end
            if (do_pop)
                rd_q <= ~rd_q;
            if (do_push && !do_pop)
                cnt_q <= cnt_q + 2'h1;
            else if (!do_push && do_pop)
                cnt_q <= cnt_q - 2'h1;
        end
    end
endmodule

`default_nettype wire

// ==== bench/uart_rx_error_irq_wake_properties.sv ====
// Port-level checks of the receive/error block
`timescale 1ns/100ps
`default_nettype none
`include "rx_err_regs.vh"
module uart_rx_error_irq_wake_properties #(
    parameter STARTUP_COUNT = 100
) (
    // Clock and reset
    input wire logic        CLK_IN,
    input wire logic        RST_N_IN,
    // APB
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic        PREADY_OUT,
    // Events
    input wire logic        TX_EMPTY_IN,
    input wire logic        TX_IDLE_IN,
    input wire logic        IRQ_N_OUT,
    input wire logic        WAKE_OUT
);
    // ============================================================
    // Shadow of the enables, taken from completed writes
    logic [7:0] ctl2_q;
    logic [7:0] pwr_q;
    logic       wake_seen_q;
    localparam int LATE = STARTUP_COUNT + 8;
    wire        wr_done = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
    wire        clk_back = wr_done && PADDR_IN == `OFS_POWER && !PWDATA_IN[0];
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ctl2_q <= 8'h00;
            pwr_q  <= 8'h00;
        end else if (wr_done && PADDR_IN == `OFS_CTRL_TWO) begin
            ctl2_q <= PWDATA_IN[7:0];
        end else if (wr_done && PADDR_IN == `OFS_POWER) begin
            pwr_q  <= PWDATA_IN[7:0];
        end
    end
    // Wake seen and not yet answered; start-up runs once the clock is back on
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN)
            wake_seen_q <= 1'b0;
        else if (WAKE_OUT)
            wake_seen_q <= 1'b1;
        else if (!IRQ_N_OUT)
            wake_seen_q <= 1'b0;
    end
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // ============================================================
    // Properties; start-up is quiet first, then the request follows
    sequence s_startup;
        IRQ_N_OUT [*3];
    endsequence
    sequence s_late_irq;
        ##[1:LATE] !IRQ_N_OUT;
    endsequence
    a_irq_one_cycle: assert property ($fell(IRQ_N_OUT) |=> IRQ_N_OUT)
        else $error("interrupt low pulse longer than one cycle");
    a_irq_has_enable: assert property ($fell(IRQ_N_OUT) |-> |ctl2_q[2:0])
        else $error("interrupt with all sources disabled");
    a_tx_empty_irq: assert property ($rose(TX_EMPTY_IN) && ctl2_q[0] && !pwr_q[0] |-> ##[1:3] !IRQ_N_OUT)
        else $error("missing interrupt for transmit empty");
    a_tx_idle_irq: assert property ($rose(TX_IDLE_IN) && ctl2_q[1] && !pwr_q[0] |-> ##[1:3] !IRQ_N_OUT)
        else $error("missing interrupt for transmitter idle");
    a_wake_one_cycle: assert property (WAKE_OUT |=> !WAKE_OUT)
        else $error("wake pulse longer than one cycle");
    a_wake_needs_bits: assert property ($rose(WAKE_OUT) |-> &{ctl2_q[7], ctl2_q[3], ctl2_q[2], pwr_q[3], pwr_q[0]})
        else $error("wake without its enables or with clock running");
    a_wake_waits: assert property (WAKE_OUT |=> s_startup)
        else $error("interrupt before start-up ended");
    a_wake_irq_late: assert property (wake_seen_q && clk_back && pwr_q[1] && pwr_q[2] |-> s_late_irq)
        else $error("no interrupt after wake start-up");
endmodule
`default_nettype wire

// ==== bench/uart_tx_model.sv ====
// Serial transmitter model on the far side of the receive line
`timescale 1ns/100ps
`default_nettype none
module uart_tx_model #(
    parameter BIT_CLKS = 16
) (
    // Clock and line
    input  wire logic clk_in,
    output var  logic rx_out
);
    // ============================================================
    // Line idles high; a level is held for one whole bit period, with an optional one-clock spike
    initial rx_out = 1'b1;
    task automatic put(input logic b, input logic g = 1'b0);
        rx_out <= b;
        repeat (8) @(posedge clk_in);
        rx_out <= b ^ g; // Spike lands on the first of the three votes
        @(posedge clk_in);
        rx_out <= b;
        repeat (BIT_CLKS - 9) @(posedge clk_in);
    endtask
    // Frame: start, data LSB first, optional parity, stop, one idle bit; glitch spikes data bit 0
    task automatic send(input logic [8:0] d, input int bits, input logic par_on, input logic par, input logic stop,
                        input logic glitch = 1'b0);
        @(posedge clk_in);
        put(1'b0);
        for (int i = 0; i < bits; i++) put(d[i], glitch && i == 0);
        if (par_on) put(par);
        put(stop);
        put(1'b1); // Idle bit lets a low stop recover
    endtask
endmodule
`default_nettype wire

// ==== bench/uart_rx_error_irq_wake_test.sv ====
// Self-checking testbench of the receive/error block
`timescale 1ns/100ps
`default_nettype none
`include "rx_err_regs.vh"
module uart_rx_error_irq_wake_test;
    // ============================================================
    // Signals and counters
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [1:0]  tx_flags = 2'b00;
    logic [31:0] rd;
    logic [31:0] prdata;
    logic        pready, pslverr, rx, irq_n, wake;
    int          errors = 0;
    int          n_checks = 0;
    int          irqs = 0;
    int          wakes = 0;
    int          base;
    uart_rx_error_irq_wake #(.STARTUP_COUNT(4)) uart_rx_error_irq_wake_inst (.CLK_IN(clk), .RST_N_IN(rst_n),
        .CE_IN(1'b1), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .RX_IN(rx),
        .TX_EMPTY_IN(tx_flags[0]), .TX_IDLE_IN(tx_flags[1]), .IRQ_N_OUT(irq_n), .WAKE_OUT(wake));
    uart_tx_model #(.BIT_CLKS(16)) uart_tx_model_inst (.clk_in(clk), .rx_out(rx));
    initial forever #10 clk = ~clk;
    // Both outputs pulse for one cycle, so one look per edge counts them
    always @(posedge clk) begin
        if (irq_n === 1'b0) irqs++;
        if (wake === 1'b1) wakes++;
    end
    // ============================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready === 1'b1) begin
            rd = prdata;
            if (pslverr === 1'b1) rd = 32'hbad;
            {psel, penable} <= 2'b00;
        end else begin
            errors++;
            test_done();
        end
    endtask
    // Status is read first so the data read pops the word
    task automatic pop(input logic [31:0] st, input logic [31:0] d);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(rd & 32'h2f, st);
        apb(1'b0, `OFS_DATA, 32'h0);
        chk(rd, d);
    endtask
    // ============================================================
    // Scenarios
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b1, `OFS_STATUS, 32'h2f);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(rd & 32'h2f, 32'h0);
        apb(1'b0, 12'h01c, 32'h0);
        chk(rd, 32'hbad);
        $display("reset and access done");
        apb(1'b1, `OFS_CTRL_ONE, 32'h80);
        apb(1'b1, `OFS_POWER, 32'h0e);
        apb(1'b1, `OFS_CTRL_TWO, 32'h84);
        base = irqs;
        uart_tx_model_inst.send(9'h0a5, 8, 1'b0, 1'b0, 1'b1);
        chk(irqs - base, 1);
        pop(32'h20, 32'ha5);
        uart_tx_model_inst.send(9'h03c, 8, 1'b0, 1'b0, 1'b0);
        pop(32'h22, 32'h3c);
        base = irqs;
        uart_tx_model_inst.send(9'h05a, 8, 1'b0, 1'b0, 1'b1, 1'b1);
        chk(irqs - base, 1);
        pop(32'h24, 32'h5a);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, `OFS_CTRL_ONE, 32'ha0 | (i << 4));
            uart_tx_model_inst.send(9'h0a5, 8, 1'b1, 1'b1, 1'b1);
            pop(32'h20 | (1 - i), 32'ha5);
        end
        apb(1'b1, `OFS_CTRL_ONE, 32'h80);
        $display("error flags done");
        base = irqs;
        for (int i = 0; i < 3; i++) uart_tx_model_inst.send(9'(17 * (i + 1)), 8, 1'b0, 1'b0, 1'b1);
        chk(irqs - base, 3);
        pop(32'h28, 32'h11);
        pop(32'h20, 32'h22);
        $display("overrun done");
        apb(1'b1, `OFS_CTRL_TWO, 32'h94);
        for (int i = 0; i < 2; i++) begin
            base = irqs;
            uart_tx_model_inst.send(9'h012 | (i << 7), 8, 1'b0, 1'b0, 1'b1);
            chk(irqs - base, i);
            pop(32'h20, 32'h12 | (i << 7));
        end
        for (int i = 0; i < 2; i++) begin
            tx_flags <= 2'b00;
            apb(1'b1, `OFS_CTRL_TWO, 32'h1 << i);
            base = irqs;
            tx_flags[1 - i] <= 1'b1;
            repeat (4) @(posedge clk);
            chk(irqs - base, 0);
            tx_flags[i] <= 1'b1;
            repeat (4) @(posedge clk);
            chk(irqs - base, 1);
        end
        $display("interrupt sources done");
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(rd & 32'h10, 32'h10);
        apb(1'b1, `OFS_CTRL_TWO, 32'h8c);
        apb(1'b1, `OFS_POWER, 32'h0f);
        base = irqs;
        uart_tx_model_inst.send(9'h000, 0, 1'b0, 1'b0, 1'b1);
        chk(wakes, 1);
        apb(1'b0, `OFS_CTRL_TWO, 32'h0);
        chk(rd, 32'h8c);
        chk(irqs - base, 0);
        // Clock comes back on; the request waits out start-up
        apb(1'b1, `OFS_POWER, 32'h0e);
        repeat (8) @(posedge clk);
        chk(irqs - base, 1);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(rd & 32'h20, 32'h0);
        $display("wake done");
        test_done();
    end
endmodule
bind uart_rx_error_irq_wake uart_rx_error_irq_wake_properties #(.STARTUP_COUNT(STARTUP_COUNT)) props_inst (
    .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
    .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PREADY_OUT(PREADY_OUT), .TX_EMPTY_IN(TX_EMPTY_IN),
    .TX_IDLE_IN(TX_IDLE_IN), .IRQ_N_OUT(IRQ_N_OUT), .WAKE_OUT(WAKE_OUT));
`default_nettype wire
